// *** core/multifunction_input_decoder.sv ***
// Operation
// [RULE_01] 3-wire init mode plus a code-00 terminal selects 3-wire, terminal gives direction
// [RULE_02] 2-wire: forward alone runs forward, reverse alone reverse, none stops
// [RULE_03] 2-wire: both inputs on flag frequency-command error and stop until cleared
// [RULE_04] code 01 on first terminal: forward press latches run, stop press releases
// [RULE_05] other codes: plain 2-wire without self-hold, stop when both open
// [RULE_06] speed commands 1..4 form a 4-bit code selecting preset code+1
// [RULE_07] first step uses preset 1, or analog inputs when source selector is 1
// [RULE_08] second step uses auxiliary analog when aux selector is 0, else preset 2
// [RULE_09] code 07 switches the accel/decel time set
// [RULE_10] switch off uses first-stage times, on uses second-stage times
// [RULE_11] baseblock while running alarms and blocks output, resumes when cleared
// [RULE_12] baseblock during decel blocks, coasts, and stays stopped after clearing
// [RULE_13] normally-open baseblock active on, normally-closed active off
// [RULE_14] ramp hold pauses accel/decel and holds present frequency
// [RULE_15] run off during hold coasts, stores frequency, releases hold
// [RULE_16] overheat input shows alarm, keeps running, clears itself
// [RULE_17] forward jog runs forward at jog preset, reverse jog reverse
// [RULE_18] jog commands take priority over all other frequency sources
// [RULE_19] both jogs on over 500 ms stops by selected stop method
// [RULE_20] external fault names terminal, blocks output, coasts to stop
// [RULE_21] normally-open fault active on, normally-closed active off
// [RULE_22] code 18 enables auxiliary analog input, disabled while PID enabled
// [RULE_23] DC brake input brakes while stopped, run or jog cancels it
// [RULE_24] local input takes commands from panel, remote indicator off
// [RULE_25] local to remote change only takes effect while stopped
// [RULE_26] all terminal inputs pass two flip-flops before decoding
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`include "mfi_cfg.svh"
module multifunction_input_decoder #(
    parameter int unsigned JOG_CONFLICT_CYCLES = `JOG_CONF_MS * `CLOCK_KHZ
) (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               fwd_terminal,
    input  wire logic               rev_terminal,
    input  wire logic [3:0]         mf_terminal,
    input  wire logic               decelerating,
    input  wire logic               drive_stopped,
    input  wire logic               pid_enable,
    output mfi_pkg::drive_cmd_t     drive_cmd,
    output mfi_pkg::freq_sel_t      freq_sel,
    output mfi_pkg::alarm_t         alarm,
    output logic                    remote_sequence_indicator
);
    // elaboration check on the conflict count
    if (JOG_CONFLICT_CYCLES < 2 || JOG_CONFLICT_CYCLES > 32'h7FFF_FFFF) begin : g_chk
        $error("JOG_CONFLICT_CYCLES out of range");
    end

    localparam logic [31:0] JOG_LIMIT = JOG_CONFLICT_CYCLES;

    // per-terminal mask of terminals assigned a given code
    function automatic logic [3:0] fn_match(input logic [31:0] fsel,
                                            input logic [4:0]  code);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (fsel[i*8 +: 5] == code);
        end
        return m;
    endfunction : fn_match

    // software registers
    logic [31:0] cfg_reg;
    logic [31:0] func_reg;
    logic [1:0]  panel_reg;
    logic        fault_clr;

    // synchronisers: first stage read only by second
    logic [5:0] raw_pins;
    logic [5:0] sync1;
    logic [5:0] sync2;
    assign raw_pins = {mf_terminal, rev_terminal, fwd_terminal};
    for (genvar g = 0; g < 6; g++) begin : g_sync
        always_ff @(posedge clock) begin
            if (!nrst) begin
                sync1[g] <= 1'b0;
                sync2[g] <= 1'b0;
            end else begin
                sync1[g] <= raw_pins[g]; // [RULE_26]
                sync2[g] <= sync1[g];    // [RULE_26]
            end
        end
    end

    logic       t_fwd;
    logic       t_rev;
    logic [3:0] t_mf;
    assign t_fwd = sync2[0];
    assign t_rev = sync2[1];
    assign t_mf  = sync2[5:2];

    // function decode
    logic [3:0] m_dir, m_ms1, m_ms2, m_ms3, m_ms4, m_acc, m_bbo, m_bbc;
    logic [3:0] m_hold, m_oh, m_fj, m_rj, m_flo, m_flc, m_aux, m_dc, m_loc;
    assign m_dir  = fn_match(func_reg, `FN_FWD_REV);
    assign m_ms1  = fn_match(func_reg, `FN_MS1);
    assign m_ms2  = fn_match(func_reg, `FN_MS2);
    assign m_ms3  = fn_match(func_reg, `FN_MS3);
    assign m_ms4  = fn_match(func_reg, `FN_MS4);
    assign m_acc  = fn_match(func_reg, `FN_ACC_SW);
    assign m_bbo  = fn_match(func_reg, `FN_BB_NO);
    assign m_bbc  = fn_match(func_reg, `FN_BB_NC);
    assign m_hold = fn_match(func_reg, `FN_HOLD);
    assign m_oh   = fn_match(func_reg, `FN_OVERHEAT);
    assign m_fj   = fn_match(func_reg, `FN_FORWARD_JOG_INPUT);
    assign m_rj   = fn_match(func_reg, `FN_REVERSE_JOG_INPUT);
    assign m_flo  = fn_match(func_reg, `FN_FLT_NO);
    assign m_flc  = fn_match(func_reg, `FN_FLT_NC);
    assign m_aux  = fn_match(func_reg, `FN_AUX_EN);
    assign m_dc   = fn_match(func_reg, `FN_DC_BRAKE);
    assign m_loc  = fn_match(func_reg, `FN_LOCAL);

    logic [3:0] wire_mode;
    logic       three_wire;
    logic       self_hold;
    logic       plain_2w;
    assign wire_mode  = cfg_reg[`CFG_WIRE_HI:`CFG_WIRE_LO];
    assign three_wire = (wire_mode == `WIRE3_A || wire_mode == `WIRE3_B
                         || wire_mode == `WIRE3_C) && |m_dir; // [RULE_01]
    assign self_hold  = !three_wire && fn_match(func_reg, `FN_STOP_KEY) == 4'h1; // [RULE_04]
    assign plain_2w   = !three_wire && !self_hold; // [RULE_05]

    // level functions, nc variants active when open
    logic bb_in, flt_in, hold_in, oh_in, acc_in, aux_in, dc_in, local_req;
    logic jog_f, jog_r, jog_any;
    assign bb_in     = |(m_bbo & t_mf) | |(m_bbc & ~t_mf); // [RULE_13]
    assign flt_in    = |(m_flo & t_mf) | |(m_flc & ~t_mf); // [RULE_21]
    assign hold_in   = |(m_hold & t_mf);
    assign oh_in     = |(m_oh & t_mf);
    assign acc_in    = |(m_acc & t_mf);
    assign aux_in    = !(|m_aux) || |(m_aux & t_mf);
    assign dc_in     = |(m_dc & t_mf);
    assign local_req = |(m_loc & t_mf);
    assign jog_f     = |(m_fj & t_mf);
    assign jog_r     = |(m_rj & t_mf);
    assign jog_any   = jog_f || jog_r;

    // run latch for 3-wire and self-holding 2-wire
    mfi_pkg::latch_state_t run_state;
    mfi_pkg::latch_state_t next_run_state;
    always_comb begin
        next_run_state = run_state;
        unique case (run_state)
            mfi_pkg::ST_STOP: begin
                if (three_wire && t_fwd && t_rev) begin
                    next_run_state = mfi_pkg::ST_RUN; // [RULE_01]
                end else if (self_hold && t_fwd && !t_rev && !t_mf[0]) begin
                    next_run_state = mfi_pkg::ST_RUN; // [RULE_04]
                end
            end
            mfi_pkg::ST_RUN: begin
                // 3-wire stop contact is normally closed
                if (three_wire && !t_rev) begin
                    next_run_state = mfi_pkg::ST_STOP;
                end else if (self_hold && (t_mf[0] || t_rev)) begin
                    next_run_state = mfi_pkg::ST_STOP; // [RULE_04]
                end else if (plain_2w) begin
                    next_run_state = mfi_pkg::ST_STOP;
                end
            end
            default: next_run_state = mfi_pkg::ST_STOP;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            run_state <= mfi_pkg::ST_STOP;
        end else begin
            run_state <= next_run_state;
        end
    end

    // terminal run command
    logic term_fwd, term_rev, dir_err, latched;
    assign latched  = (run_state == mfi_pkg::ST_RUN);
    assign dir_err  = plain_2w && t_fwd && t_rev; // [RULE_03]
    always_comb begin
        term_fwd = 1'b0;
        term_rev = 1'b0;
        if (three_wire) begin
            term_fwd = latched && !(|(m_dir & t_mf)); // [RULE_01]
            term_rev = latched && |(m_dir & t_mf);
        end else if (self_hold) begin
            term_fwd = latched; // [RULE_04]
        end else begin
            term_fwd = t_fwd && !t_rev; // [RULE_02]
            term_rev = t_rev && !t_fwd; // [RULE_02]
        end
    end

    // local/remote source; leaving local waits for stop
    logic local_mode;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            local_mode <= 1'b0;
        end else if (local_req) begin
            local_mode <= 1'b1;
        end else if (drive_stopped) begin
            local_mode <= 1'b0; // [RULE_25]
        end
    end

    logic use_term, src_fwd, src_rev;
    assign use_term = !local_mode && cfg_reg[`CFG_RUN_SRC]; // [RULE_24]
    assign src_fwd  = use_term ? term_fwd : panel_reg[0];
    assign src_rev  = use_term ? term_rev : panel_reg[1];

    // jog conflict timer; saturates at limit
    logic [31:0] jog_cnt;
    logic        jog_conflict;
    assign jog_conflict = (jog_cnt == JOG_LIMIT);
    always_ff @(posedge clock) begin
        if (!nrst || !(jog_f && jog_r)) begin
            jog_cnt <= 32'h0000_0000;
        end else if (!jog_conflict) begin
            jog_cnt <= jog_cnt + 32'h0000_0001; // [RULE_19]
        end
    end

    // jog overrides every other command
    logic cmd_fwd, cmd_rev, run_req, run_req_d;
    assign cmd_fwd = jog_any ? (jog_f && !jog_conflict) : src_fwd; // [RULE_18]
    assign cmd_rev = jog_any ? (jog_r && !jog_f) : src_rev;        // [RULE_17]
    assign run_req = cmd_fwd || cmd_rev;

    // baseblock during decel keeps drive stopped until run drops
    logic bb_stop;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bb_stop <= 1'b0;
        end else if (bb_in && decelerating) begin
            bb_stop <= 1'b1; // [RULE_12]
        end else if (!run_req) begin
            bb_stop <= 1'b0;
        end
    end

    // ramp hold release after run drops under hold
    logic hold_rel;
    logic hold_stop;
    assign hold_stop = hold_in && run_req_d && !run_req;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            run_req_d <= 1'b0;
            hold_rel  <= 1'b0;
        end else begin
            run_req_d <= run_req;
            if (hold_stop) begin
                hold_rel <= 1'b1; // [RULE_15]
            end else if (!hold_in) begin
                hold_rel <= 1'b0;
            end
        end
    end

    // external fault latch, set wins over clear
    logic       fault;
    logic [3:0] fault_term;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            fault      <= 1'b0;
            fault_term <= 4'h0;
        end else if (flt_in) begin
            fault <= 1'b1; // [RULE_20]
            for (int i = 3; i >= 0; i--) begin
                if ((m_flo[i] && t_mf[i]) || (m_flc[i] && !t_mf[i])) begin
                    fault_term <= `FIRST_TERM + 4'(i); // [RULE_20]
                end
            end
        end else if (fault_clr) begin
            fault <= 1'b0;
        end
    end

    // output stage: everything registered
    logic stop_all;
    assign stop_all = fault || bb_in || bb_stop || dir_err || hold_rel || hold_stop
                      || jog_conflict;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            drive_cmd <= '0;
        end else begin
            drive_cmd.run_fwd      <= cmd_fwd && !stop_all; // [RULE_11]
            drive_cmd.run_rev      <= cmd_rev && !stop_all; // [RULE_03]
            drive_cmd.output_block <= fault || flt_in || bb_in || bb_stop; // [RULE_11]
            drive_cmd.coast_stop   <= fault || flt_in || bb_stop || hold_stop || hold_rel
                                      || (jog_conflict && cfg_reg[`CFG_STOP_MTH]); // [RULE_19]
            drive_cmd.decel_stop   <= jog_conflict && !cfg_reg[`CFG_STOP_MTH];
            drive_cmd.dc_brake     <= dc_in && !run_req; // [RULE_23]
            drive_cmd.ramp_hold    <= hold_in && !hold_rel && !hold_stop; // [RULE_14]
            drive_cmd.accel_set2   <= acc_in; // [RULE_09] [RULE_10]
            drive_cmd.store_freq   <= hold_stop; // [RULE_15]
        end
    end

    // frequency source selection
    logic [3:0] step_code;
    assign step_code = {|(m_ms4 & t_mf), |(m_ms3 & t_mf),
                        |(m_ms2 & t_mf), |(m_ms1 & t_mf)}; // [RULE_06]
    always_ff @(posedge clock) begin
        if (!nrst) begin
            freq_sel <= '0;
        end else begin
            freq_sel.preset_index <= jog_any ? 4'h0 : step_code;
            freq_sel.aux_enable   <= aux_in && !pid_enable; // [RULE_22]
            if (jog_any) begin
                freq_sel.src <= mfi_pkg::SRC_JOG; // [RULE_18]
            end else if (local_mode) begin
                freq_sel.src <= mfi_pkg::SRC_PANEL; // [RULE_24]
            end else if (step_code == 4'h0 && cfg_reg[`CFG_FREQ_SRC]) begin
                freq_sel.src <= mfi_pkg::SRC_ANALOG; // [RULE_07]
            end else if (step_code == 4'h1
                         && cfg_reg[`CFG_AUX_HI:`CFG_AUX_LO] == 4'h0) begin
                freq_sel.src <= mfi_pkg::SRC_AUX; // [RULE_08]
            end else begin
                freq_sel.src <= mfi_pkg::SRC_PRESET;
            end
        end
    end

    // alarm indications
    always_ff @(posedge clock) begin
        if (!nrst) begin
            alarm                     <= '0;
            remote_sequence_indicator <= 1'b1;
        end else begin
            alarm.freq_cmd_error      <= dir_err && use_term; // [RULE_03]
            alarm.baseblock_alarm     <= bb_in; // [RULE_11]
            alarm.overheat_alarm      <= oh_in; // [RULE_16]
            alarm.ext_fault           <= fault || flt_in;
            // keeps naming the last faulted terminal even after the latch clears
            alarm.fault_terminal      <= fault_term; // [RULE_20]
            remote_sequence_indicator <= !local_mode; // [RULE_24]
        end
    end

    // wishbone slave: ack one cycle after strobe
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfg_reg   <= `CFG_RESET;
            func_reg  <= `FUNC_RESET;
            panel_reg <= 2'h0;
            fault_clr <= 1'b0;
        end else begin
            fault_clr <= req && wb_we_i && wb_adr_i == `ADDR_FAULT
                         && wb_sel_i[0] && wb_dat_i[0];
            if (req && wb_we_i) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b] && wb_adr_i == `ADDR_CFG) begin
                        cfg_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                    end
                    if (wb_sel_i[b] && wb_adr_i == `ADDR_FUNC) begin
                        func_reg[b*8 +: 8] <= {3'h0, wb_dat_i[b*8 +: 5]};
                    end
                end
                if (wb_sel_i[0] && wb_adr_i == `ADDR_PANEL) begin
                    panel_reg <= wb_dat_i[1:0];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `ADDR_CFG:    wb_dat_o <= cfg_reg;
                    `ADDR_FUNC:   wb_dat_o <= func_reg;
                    `ADDR_PANEL:  wb_dat_o <= {30'h0, panel_reg};
                    `ADDR_STATUS: wb_dat_o <= {16'h0, 3'(freq_sel.src), local_mode,
                                               alarm, drive_cmd.run_fwd,
                                               drive_cmd.run_rev, 2'h0};
                    `ADDR_FAULT:  wb_dat_o <= {27'h0, fault_term, fault};
                    default:      wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_dir_err;
        dir_err && use_term |=> alarm.freq_cmd_error && !drive_cmd.run_fwd
                                && !drive_cmd.run_rev;
    endproperty
    a_dir_err: assert property (p_dir_err) else $error("dir conflict not stopped"); // [RULE_03]

    property p_jog_prio;
        jog_f && !jog_r |=> freq_sel.src == mfi_pkg::SRC_JOG;
    endproperty
    a_jog_prio: assert property (p_jog_prio) else $error("jog not prioritised"); // [RULE_18]

    property p_jog_conf;
        jog_conflict |=> !drive_cmd.run_fwd && !drive_cmd.run_rev
                         && (drive_cmd.coast_stop || drive_cmd.decel_stop);
    endproperty
    a_jog_conf: assert property (p_jog_conf) else $error("jog conflict ran on"); // [RULE_19]

    property p_fault;
        flt_in |=> alarm.ext_fault && drive_cmd.coast_stop && drive_cmd.output_block
                   ##1 alarm.fault_terminal >= `FIRST_TERM;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not blocking"); // [RULE_20]

    property p_overheat;
        oh_in |=> alarm.overheat_alarm;
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat not shown"); // [RULE_16]

    property p_remote_defer;
        local_mode && !local_req && !drive_stopped |=> local_mode
                                                       ##1 !remote_sequence_indicator;
    endproperty
    a_remote_defer: assert property (p_remote_defer) else $error("remote not deferred"); // [RULE_25]

    property p_baseblock;
        bb_in |=> drive_cmd.output_block && alarm.baseblock_alarm && !drive_cmd.run_fwd;
    endproperty
    a_baseblock: assert property (p_baseblock) else $error("baseblock not applied"); // [RULE_11]

    property p_dc_brake;
        dc_in && !run_req |=> drive_cmd.dc_brake && !drive_cmd.run_fwd
                              && !drive_cmd.run_rev;
    endproperty
    a_dc_brake: assert property (p_dc_brake) else $error("dc brake missing"); // [RULE_23]

    property p_bb_decel;
        bb_in && decelerating ##1 !bb_in && run_req |=> !drive_cmd.run_fwd
                                                        && !drive_cmd.run_rev;
    endproperty
    a_bb_decel: assert property (p_bb_decel) else $error("restart after decel block"); // [RULE_12]

    c_self_hold: cover property (self_hold && latched ##1 drive_cmd.run_fwd);
    c_jog_conf:  cover property (jog_conflict);
    c_bb_decel:  cover property (bb_in && decelerating);
    c_to_remote: cover property (local_mode ##1 !local_mode);
endmodule : multifunction_input_decoder

// *** core/mfi_cfg.svh ***
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH
// register byte addresses
`define ADDR_CFG      8'h00
`define ADDR_FUNC     8'h04
`define ADDR_PANEL    8'h08
`define ADDR_STATUS   8'h0C
`define ADDR_FAULT    8'h10
// config field positions
`define CFG_WIRE_LO   0
`define CFG_WIRE_HI   3
`define CFG_RUN_SRC   4
`define CFG_FREQ_SRC  5
`define CFG_STOP_MTH  6
`define CFG_AUX_LO    8
`define CFG_AUX_HI    11
`define CFG_RESET     32'h0000_0000
`define FUNC_RESET    32'h0504_0302
// terminal function codes
`define FN_FWD_REV    5'h00
`define FN_STOP_KEY   5'h01
`define FN_MS1        5'h02
`define FN_MS2        5'h03
`define FN_MS3        5'h04
`define FN_MS4        5'h05
`define FN_ACC_SW     5'h07
`define FN_BB_NO      5'h08
`define FN_BB_NC      5'h09
`define FN_HOLD       5'h0A
`define FN_OVERHEAT   5'h0B
`define FN_FORWARD_JOG_INPUT       5'h0C
`define FN_REVERSE_JOG_INPUT       5'h0D
`define FN_FLT_NO     5'h10
`define FN_FLT_NC     5'h11
`define FN_AUX_EN     5'h12
`define FN_DC_BRAKE   5'h14
`define FN_LOCAL      5'h17
// 3-wire initialisation modes
`define WIRE3_A       4'h8
`define WIRE3_B       4'hA
`define WIRE3_C       4'hC
`define FIRST_TERM    4'h5
// jog conflict time
`define JOG_CONF_MS   500
`define CLOCK_KHZ     250000
`endif

// *** core/mfi_pkg.sv ***
package mfi_pkg;
    typedef enum logic [2:0] {
        SRC_PRESET = 3'b000,
        SRC_ANALOG = 3'b001,
        SRC_AUX    = 3'b010,
        SRC_JOG    = 3'b011,
        SRC_PANEL  = 3'b100
    } freq_src_t;
    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_RUN  = 2'b01
    } latch_state_t;
    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic output_block;
        logic coast_stop;
        logic decel_stop;
        logic dc_brake;
        logic ramp_hold;
        logic accel_set2;
        logic store_freq;
    } drive_cmd_t;
    typedef struct packed {
        freq_src_t  src;
        logic [3:0] preset_index;
        logic       aux_enable;
    } freq_sel_t;
    typedef struct packed {
        logic       freq_cmd_error;
        logic       baseblock_alarm;
        logic       overheat_alarm;
        logic       ext_fault;
        logic [3:0] fault_terminal;
    } alarm_t;
endpackage : mfi_pkg

// *** tb/contact_bank.sv ***
module contact_bank (
    input  wire logic       want_fwd,
    input  wire logic       want_rev,
    input  wire logic [3:0] want_mf,
    output logic            fwd_terminal,
    output logic            rev_terminal,
    output logic [3:0]      mf_terminal
);
    timeunit 1ns;
    timeprecision 1ps;
    // contacts open at power up
    initial {fwd_terminal, rev_terminal, mf_terminal} = 6'h00;
    // contacts move 1.3 ns after each request, part way into the cycle that follows the clock edge
    always @(want_fwd, want_rev, want_mf) begin
        #1.3 {fwd_terminal, rev_terminal, mf_terminal} = {want_fwd, want_rev, want_mf};
    end
endmodule : contact_bank

// *** tb/multifunction_input_decoder_tb.sv ***
module multifunction_input_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clock = 1'b0;
    logic                nrst = 1'b0;
    logic                cyc = 1'b0;
    logic                stb = 1'b0;
    logic                we = 1'b0;
    logic [7:0]          adr = 8'h00;
    logic [31:0]         dat = 32'h0;
    logic [31:0]         rdat;
    logic                ack;
    logic                fwd_w = 1'b0;
    logic                rev_w = 1'b0;
    logic [3:0]          mf_w = 4'h0;
    logic                pid = 1'b0;
    logic                decel = 1'b0;
    logic                stopped = 1'b1;
    logic                rsi;
    wire logic           fwd_t;
    wire logic           rev_t;
    wire logic [3:0]     mf_t;
    mfi_pkg::drive_cmd_t dcmd;
    mfi_pkg::freq_sel_t  fsel;
    mfi_pkg::alarm_t     alm;
    int                  num_errors = 0;
    int                  comparisons = 0;
    int                  cycles = 0;
    int                  v;
    logic [31:0]         exp_q[$];
    always #2 clock = ~clock;
    contact_bank partner (.want_fwd(fwd_w), .want_rev(rev_w), .want_mf(mf_w),
        .fwd_terminal(fwd_t), .rev_terminal(rev_t), .mf_terminal(mf_t));
    multifunction_input_decoder #(.JOG_CONFLICT_CYCLES(20)) dut (.clock(clock), .nrst(nrst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .fwd_terminal(fwd_t),
        .rev_terminal(rev_t), .mf_terminal(mf_t), .decelerating(decel), .drive_stopped(stopped),
        .pid_enable(pid), .drive_cmd(dcmd), .freq_sel(fsel), .alarm(alm),
        .remote_sequence_indicator(rsi));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // one classic cycle, entered just after an edge; waits for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        {cyc, stb} <= 2'b00;
        @(posedge clock);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // contacts move, then sync plus decode settle
    task automatic set(input logic f, input logic r, input logic [3:0] m);
        {fwd_w, rev_w, mf_w} <= {f, r, m};
        repeat (6) @(posedge clock);
    endtask : set
    // read data taken at the ack edge against the oldest note
    always @(posedge clock) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
        check(rdat, exp_q.pop_front());
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(11152));
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rd(8'h04, 32'h0504_0302);
        rd(8'h20, 32'h0);
        bus(1'b1, 8'h00, 32'h10);
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            set(i[0], i[1], 4'h0);
            check({dcmd.run_fwd, dcmd.run_rev}, (i == 1) ? 2 : (i == 2) ? 1 : 0);
            check(alm.freq_cmd_error, i == 3);
        end
        $display("two wire done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 1 : $urandom_range(15, 0);
            pid <= v[1];
            set(1'b1, 1'b0, v[3:0]);
            check(fsel.preset_index, v[3:0]);
            check(fsel.src, (v == 1) ? mfi_pkg::SRC_AUX : mfi_pkg::SRC_PRESET);
            check(fsel.aux_enable, !v[1]);
        end
        $display("steps done");
        // open all contacts so the new codes see no stray fault or baseblock
        set(1'b0, 1'b0, 4'h0);
        bus(1'b1, 8'h04, 32'h0810_0D0C);
        set(1'b0, 1'b0, 4'h2);
        check({dcmd.run_fwd, dcmd.run_rev}, 2'b01);
        check(fsel.src, mfi_pkg::SRC_JOG);
        set(1'b0, 1'b0, 4'h3);
        check({dcmd.run_fwd, dcmd.decel_stop}, 2'b10);
        repeat (30) @(posedge clock);
        check(dcmd.decel_stop, 1'b1);
        $display("jog done");
        set(1'b1, 1'b0, 4'h8);
        check({alm.baseblock_alarm, dcmd.output_block}, 2'b11);
        set(1'b1, 1'b0, 4'h0);
        check({dcmd.output_block, dcmd.run_fwd}, 2'b01);
        set(1'b1, 1'b0, 4'h4);
        check({alm.ext_fault, alm.fault_terminal, dcmd.output_block}, 6'h2F);
        rd(8'h10, 32'h0F);
        $display("protection done");
        set(1'b1, 1'b0, 4'h0);
        bus(1'b1, 8'h10, 32'h1);
        rd(8'h10, 32'h0E);
        decel <= 1'b1;
        set(1'b1, 1'b0, 4'h8);
        decel <= 1'b0;
        set(1'b1, 1'b0, 4'h0);
        check({dcmd.run_fwd, dcmd.coast_stop}, 2'b01);
        set(1'b0, 1'b0, 4'h0);
        $display("decel block done");
        bus(1'b1, 8'h04, 32'h1710_0D0C);
        stopped <= 1'b0;
        set(1'b0, 1'b0, 4'h8);
        check({rsi, fsel.src}, {1'b0, mfi_pkg::SRC_PANEL});
        set(1'b0, 1'b0, 4'h0);
        check(rsi, 1'b0);
        stopped <= 1'b1;
        set(1'b0, 1'b0, 4'h0);
        check(rsi, 1'b1);
        $display("remote done");
        bus(1'b1, 8'h04, 32'h1710_0D01);
        set(1'b1, 1'b0, 4'h0);
        set(1'b0, 1'b0, 4'h0);
        check(dcmd.run_fwd, 1'b1);
        set(1'b0, 1'b0, 4'h1);
        check(dcmd.run_fwd, 1'b0);
        $display("self hold done");
        give_verdict();
    end
endmodule : multifunction_input_decoder_tb
